// ### dv/watchdog_ctrl_status_guard_tb.sv
// Testbench: guarded register writes, watchdog and interval overflow
`timescale 1ns/10ps
module watchdog_ctrl_status_guard_tb;
  localparam logic [7:0] GA = watchdog_pkg::GUARD_OFF;
  localparam logic [7:0] MA = watchdog_pkg::MODE_OFF;
  localparam logic [7:0] CA = watchdog_pkg::COUNT_OFF;
  localparam logic [7:0] KA = watchdog_pkg::CKSEL_OFF;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic subClk = 1'b0;
  logic oscClk = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready, pslverr, chipResetReq, intervalIrq, err;
  int errors = 0;
  int num_checks = 0;
  int rstSeen = 0;
  int n;
  // Oscillator held still so counter values read back exactly
  always #50 clk = ~clk;
  always #370 subClk = ~subClk;
  // Cycles of reset request, to prove single pulses
  always @(posedge clk) if (chipResetReq === 1'b1) rstSeen++;
  watchdog_ctrl_status_guard u_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .subClk(subClk), .oscClk(oscClk),
    .chipResetReq(chipResetReq), .intervalIrq(intervalIrq));
  task automatic tally_and_finish();
    if (errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One bus transfer; request held until ready is sampled
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      tally_and_finish();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 8'h00);
    chk(nm, q, {24'h0, e});
  endtask
  task automatic gstep(input logic [7:0] d, input logic [7:0] e);
    xfer(GA, 1'b1, d);
    rdchk("guard", GA, e);
  endtask
  // Bounded wait for reset request or interrupt
  task automatic wait_event(input logic irq);
    n = 0;
    while ((irq ? intervalIrq : chipResetReq) !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task automatic t_reset();
    rdchk("guard", GA, 8'hAE);
    rdchk("mode", MA, 8'h57);
    rdchk("count", CA, 8'h00);
    rdchk("cksel", KA, 8'hF0);
    rdchk("standby", watchdog_pkg::STBY_OFF, 8'h00);
  endtask
  task automatic t_guard();
    xfer(CA, 1'b1, 8'h55);
    rdchk("count", CA, 8'h00);
    gstep(8'hBF, 8'hAE);
    gstep(8'h9A, 8'hBE);
    gstep(8'hB3, 8'hBA);
    gstep(8'h6A, 8'hFA);
    gstep(8'h8E, 8'hEA);
    gstep(8'hA5, 8'hEA);
    xfer(CA, 1'b1, 8'h33);
    rdchk("count", CA, 8'h33);
  endtask
  task automatic t_wdog();
    xfer(CA, 1'b1, 8'hF0);
    xfer(KA, 1'b1, 8'h08);
    gstep(8'h9E, 8'hFA);
    gstep(8'hB6, 8'hFE);
    wait_event(1'b0);
    rdchk("guard", GA, 8'hAF);
    rdchk("count", CA, 8'h00);
    rdchk("mode", MA, 8'h57);
    chk("resets", rstSeen, 32'h1);
  endtask
  task automatic t_status();
    gstep(8'hAC, 8'hAF);
    gstep(8'h9E, 8'hBF);
    gstep(8'hB8, 8'hBE);
  endtask
  task automatic t_interval();
    xfer(MA, 1'b1, 8'h28);
    rdchk("mode", MA, 8'h7F);
    gstep(8'h7E, 8'hFE);
    xfer(CA, 1'b1, 8'hF0);
    xfer(KA, 1'b1, 8'h04);
    wait_event(1'b1);
    rdchk("mode", MA, 8'hFF);
    xfer(MA, 1'b1, 8'h7F);
    rdchk("mode", MA, 8'h7F);
    chk("resets", rstSeen, 32'h1);
  endtask
  task automatic t_unmapped();
    xfer(8'h20, 1'b0, 8'h00);
    chk("slverr", {31'h0, err}, 32'h1);
    chk("rdata", q, 32'h0);
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_guard();
    t_wdog();
    t_status();
    t_interval();
    t_unmapped();
    tally_and_finish();
  end
endmodule

// ### dv/watchdog_guard_monitor.sv
// Checker: bus and output assertions for the watchdog guard block
`timescale 1ns/10ps
module watchdog_guard_monitor (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic subClk, // Subclock
  input wire logic oscClk, // Oscillator
  input wire logic chipResetReq, // Reset request
  input wire logic intervalIrq // Interrupt
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Access decode
  wire logic acc = psel && penable;
  wire logic rd = acc && !pwrite;
  sequence s_pulse;
    chipResetReq ##1 !chipResetReq;
  endsequence
  property p_ready;
    acc |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("ready missing in access");
  property p_idle;
    !acc |-> !pready && !pslverr;
  endproperty
  a_idle: assert property (p_idle) else $error("ready or error outside access");
  property p_unmap;
    rd && paddr > watchdog_pkg::STBY_OFF |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  property p_guard;
    rd && paddr == watchdog_pkg::GUARD_OFF |-> !pslverr && prdata[31:8] == 24'h0
      && (prdata[7:0] & watchdog_pkg::GUARD_ONES) == watchdog_pkg::GUARD_ONES;
  endproperty
  a_guard: assert property (p_guard) else $error("guard inhibit bits not one");
  property p_mode;
    rd && paddr == watchdog_pkg::MODE_OFF |-> !pslverr
      && (prdata[7:0] & watchdog_pkg::MODE_ONES) == watchdog_pkg::MODE_ONES;
  endproperty
  a_mode: assert property (p_mode) else $error("mode fixed bits not one");
  property p_pulse;
    $rose(chipResetReq) |-> s_pulse ##1 !chipResetReq [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("reset request not one pulse");
  property p_noirq;
    chipResetReq |-> !intervalIrq;
  endproperty
  a_noirq: assert property (p_noirq) else $error("reset and interrupt together");
  property p_hold;
    rd |=> $stable(prdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data not held");
endmodule

bind watchdog_ctrl_status_guard watchdog_guard_monitor u_mon (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .subClk(subClk), .oscClk(oscClk),
  .chipResetReq(chipResetReq), .intervalIrq(intervalIrq));

// ### src/watchdog_ctrl_status_guard.sv
// Watchdog / interval timer with guarded control registers behind an APB slave
`timescale 1ns/10ps

module watchdog_ctrl_status_guard (
  input wire logic clk, // System clock, 10 MHz
  input wire logic rst_n, // External reset pin, async, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic subClk, // Subclock pin, asynchronous
  input wire logic oscClk, // On-chip oscillator, asynchronous
  output logic chipResetReq, // Internal reset pulse, one cycle
  output logic intervalIrq // Interval timer interrupt level
);

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  // Local copy of the prescaler width, declared before its first use
  localparam int PRESC_W_LOCAL = watchdog_pkg::PRESC_W;

  watchdog_pkg::wdt_state_t st_reg;
  watchdog_pkg::wdt_state_t st_next;

  logic setupPhase;
  logic accessPhase;
  logic wrAccess;
  logic rdAccess;
  logic mapped;
  logic tick;
  logic wrap;
  logic [7:0] wd;
  logic [7:0] guardView;
  logic [7:0] modeView;
  logic [7:0] readByte;
  logic [PRESC_W_LOCAL-1:0] sysMask;
  logic [PRESC_W_LOCAL-1:0] sysOnes;
  logic subEdge;
  logic oscEdge;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // No wait states: the read byte is captured in the setup cycle
  assign setupPhase = psel & ~penable;
  assign accessPhase = psel & penable;
  assign wrAccess = accessPhase & pwrite & mapped;
  assign rdAccess = accessPhase & ~pwrite & mapped;
  assign wd = pwdata[7:0];
  assign pready = accessPhase;
  assign pslverr = accessPhase & ~mapped;
  assign prdata = st_reg.rdata;
  assign chipResetReq = st_reg.rstPulse;
  assign intervalIrq = st_reg.irq;

  // Address decode and read mux
  always_comb begin
    mapped = 1'b1;
    readByte = 8'h00;
    if (paddr == watchdog_pkg::GUARD_OFF) begin
      readByte = guardView;
    end else if (paddr == watchdog_pkg::MODE_OFF) begin
      readByte = modeView;
    end else if (paddr == watchdog_pkg::COUNT_OFF) begin
      readByte = st_reg.count;
    end else if (paddr == watchdog_pkg::CKSEL_OFF) begin
      readByte = watchdog_pkg::CKSEL_ONES | {4'h0, st_reg.cks};
    end else if (paddr == watchdog_pkg::STBY_OFF) begin
      readByte = {7'h00, st_reg.standby};
    end else begin
      mapped = 1'b0;
    end
  end

  // Register views; inhibit and reserved positions read as one
  always_comb begin
    guardView = watchdog_pkg::GUARD_ONES;
    guardView[watchdog_pkg::CWE_BIT] = st_reg.cwe;
    guardView[watchdog_pkg::RWE_BIT] = st_reg.rwe;
    guardView[watchdog_pkg::RUN_BIT] = st_reg.run;
    guardView[watchdog_pkg::RST_BIT] = st_reg.rstStat;
    modeView = watchdog_pkg::MODE_ONES;
    modeView[watchdog_pkg::OVF_BIT] = st_reg.ovf;
    modeView[watchdog_pkg::MODE_BIT] = st_reg.intervalMode;
    modeView[watchdog_pkg::IE_BIT] = st_reg.ovfIrqEn;
  end

  // ----------------------------------------
  // Counter clock selection
  // ----------------------------------------
  // System divisions are taps of one free prescaler, so all share phase
  assign subEdge = st_reg.subSync[1] & ~st_reg.subPrev;
  assign oscEdge = st_reg.oscSync[1] & ~st_reg.oscPrev;
  assign sysOnes = '1;
  assign sysMask = PRESC_W_LOCAL'(sysOnes >> (3'd7 - st_reg.cks[2:0]));

  always_comb begin
    tick = 1'b0;
    if (st_reg.cks[3]) begin
      tick = (st_reg.presc & sysMask) == sysMask;
    end else if (st_reg.cks == watchdog_pkg::CKS_SUB16) begin
      tick = subEdge & (st_reg.subDiv[3:0] == watchdog_pkg::SUB16_MASK);
    end else if (st_reg.cks == watchdog_pkg::CKS_SUB256) begin
      tick = subEdge & (st_reg.subDiv == watchdog_pkg::SUB256_MASK);
    end else begin
      tick = oscEdge;
    end
  end

  // Standby and a cleared run bit both freeze the counter
  assign wrap = tick & st_reg.run & ~st_reg.standby
              & (st_reg.count == watchdog_pkg::COUNT_MAX);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.rstPulse = 1'b0;

    // Synchronisers; the first stage feeds only the second
    st_next.subSync = {st_reg.subSync[0], subClk};
    st_next.subPrev = st_reg.subSync[1];
    st_next.oscSync = {st_reg.oscSync[0], oscClk};
    st_next.oscPrev = st_reg.oscSync[1];

    // Prescalers stop in standby, as the module clock would
    if (!st_reg.standby) begin
      st_next.presc = st_reg.presc + 1'b1;
      if (subEdge) begin
        st_next.subDiv = st_reg.subDiv + 8'h01;
      end
    end

    // Count while running
    if (tick && st_reg.run && !st_reg.standby) begin
      st_next.count = st_reg.count + 8'h01;
    end

    // Read data captured in the setup cycle
    if (setupPhase) begin
      st_next.rdata = {24'h00_0000, readByte};
    end

    // Reading the flag as one arms its clear
    if (rdAccess && paddr == watchdog_pkg::MODE_OFF && st_reg.ovf) begin
      st_next.ovfArmed = 1'b1;
    end

    // Register writes; low byte of write data taken, guards checked per field
    if (wrAccess) begin
      if (paddr == watchdog_pkg::GUARD_OFF) begin
        if (!wd[watchdog_pkg::CWE_INH]) begin
          st_next.cwe = wd[watchdog_pkg::CWE_BIT];
        end
        if (!wd[watchdog_pkg::RWE_INH]) begin
          st_next.rwe = wd[watchdog_pkg::RWE_BIT];
        end
        // The enable must already be set before this write
        if (st_reg.rwe && !wd[watchdog_pkg::RUN_INH]) begin
          st_next.run = wd[watchdog_pkg::RUN_BIT];
        end
        if (st_reg.rwe && !wd[watchdog_pkg::RST_INH]) begin
          st_next.rstStat = wd[watchdog_pkg::RST_BIT];
        end
      end else if (paddr == watchdog_pkg::MODE_OFF) begin
        if (!wd[watchdog_pkg::MODE_INH]) begin
          st_next.intervalMode = wd[watchdog_pkg::MODE_BIT];
        end
        if (!wd[watchdog_pkg::IE_INH]) begin
          st_next.ovfIrqEn = wd[watchdog_pkg::IE_BIT];
        end
        if (st_reg.ovfArmed && !wd[watchdog_pkg::OVF_BIT]) begin
          st_next.ovf = 1'b0;
          st_next.ovfArmed = 1'b0;
        end
      end else if (paddr == watchdog_pkg::COUNT_OFF) begin
        // Software kick overrides a same-cycle increment, but a same-cycle overflow reset in watchdog mode overrides the kick
        if (st_reg.cwe) begin
          st_next.count = wd;
        end
      end else if (paddr == watchdog_pkg::CKSEL_OFF) begin
        st_next.cks = wd[3:0];
      end else begin
        st_next.standby = wd[0];
      end
    end

    // Overflow: flag set wins over a same-cycle clear
    if (wrap) begin
      st_next.ovf = 1'b1;
      st_next.ovfArmed = 1'b0;
      if (!st_reg.intervalMode) begin
        // Internal reset re-initialises all but the synchronisers, then sets the status bit
        st_next = watchdog_pkg::STATE_RESET;
        st_next.subSync = {st_reg.subSync[0], subClk};
        st_next.subPrev = st_reg.subSync[1];
        st_next.oscSync = {st_reg.oscSync[0], oscClk};
        st_next.oscPrev = st_reg.oscSync[1];
        st_next.rstStat = 1'b1;
        st_next.rstPulse = 1'b1;
      end
    end

    // Interrupt level follows flag, enable and interval mode
    st_next.irq = st_next.ovf & st_next.ovfIrqEn & st_next.intervalMode;
  end

  // ----------------------------------------
  // State flops
  // ----------------------------------------
  // Pin reset restores everything, setting run and clearing status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= watchdog_pkg::STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// ### src/watchdog_pkg.sv
// Package: register map, field positions, reset values and state type of the watchdog
package watchdog_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] GUARD_OFF = 8'h00;
  localparam logic [7:0] MODE_OFF = 8'h04;
  localparam logic [7:0] COUNT_OFF = 8'h08;
  localparam logic [7:0] CKSEL_OFF = 8'h0C;
  localparam logic [7:0] STBY_OFF = 8'h10;

  // ----------------------------------------
  // Guard control field positions
  // ----------------------------------------
  localparam int CWE_INH = 7;
  localparam int CWE_BIT = 6;
  localparam int RWE_INH = 5;
  localparam int RWE_BIT = 4;
  localparam int RUN_INH = 3;
  localparam int RUN_BIT = 2;
  localparam int RST_INH = 1;
  localparam int RST_BIT = 0;

  // ----------------------------------------
  // Mode control field positions
  // ----------------------------------------
  localparam int OVF_BIT = 7;
  localparam int MODE_INH = 6;
  localparam int MODE_BIT = 5;
  localparam int IE_INH = 4;
  localparam int IE_BIT = 3;

  // Bits that always read as one
  localparam logic [7:0] GUARD_ONES = 8'hAA;
  localparam logic [7:0] MODE_ONES = 8'h57;
  localparam logic [7:0] CKSEL_ONES = 8'hF0;

  // ----------------------------------------
  // Clock source selection and counter reset and maximum values
  // ----------------------------------------
  localparam int PRESC_W = 13;
  localparam int SYS_DIV_BASE = 6;
  localparam logic [3:0] CKS_SUB16 = 4'h4;
  localparam logic [3:0] CKS_SUB256 = 4'h5;
  localparam logic [3:0] CKS_RESET = 4'h0;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [3:0] SUB16_MASK = 4'hF;
  localparam logic [7:0] SUB256_MASK = 8'hFF;

  // All state of the block
  typedef struct packed {
    logic cwe;
    logic rwe;
    logic run;
    logic rstStat;
    logic ovf;
    logic ovfArmed;
    logic intervalMode;
    logic ovfIrqEn;
    logic [3:0] cks;
    logic standby;
    logic [7:0] count;
    logic [PRESC_W-1:0] presc;
    logic [1:0] subSync;
    logic subPrev;
    logic [7:0] subDiv;
    logic [1:0] oscSync;
    logic oscPrev;
    logic [31:0] rdata;
    logic rstPulse;
    logic irq;
  } wdt_state_t;

  localparam wdt_state_t STATE_RESET = '{
    cwe: 1'b0, rwe: 1'b0, run: 1'b1, rstStat: 1'b0, ovf: 1'b0, ovfArmed: 1'b0,
    intervalMode: 1'b0, ovfIrqEn: 1'b0, cks: CKS_RESET, standby: 1'b0,
    count: COUNT_RESET, presc: '0, subSync: 2'h0, subPrev: 1'b0, subDiv: 8'h00,
    oscSync: 2'h0, oscPrev: 1'b0, rdata: 32'h0000_0000, rstPulse: 1'b0, irq: 1'b0
  };

endpackage
